// file: hw/frr_pkg.sv
package frr_pkg;
    // Response byte layout
    localparam int RESP_HI  = 7;
    localparam int RESP_LO  = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI   = 2;
    localparam int DLY_LO   = 0;

    // Response codes
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RUNON  = 2'h1;
    localparam logic [1:0] RESP_OFF    = 2'h2;
    localparam logic [1:0] RESP_LATCH  = 2'h3;

    // Retry codes
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_CONT = 3'h7;

    // Delay unit count width, enough for 128 units
    localparam int         UNITS_W   = 8;
    localparam logic [7:0] UNITS_ONE = 8'h01;

    // Clock and default time unit
    localparam int CLK_PERIOD_NS = 50;
    localparam int UNIT_NS       = 1000000;
    localparam int UNIT_CYC      = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_RUN   = 5'h01,
        ST_GRACE = 5'h02,
        ST_WAIT  = 5'h04,
        ST_TRY   = 5'h08,
        ST_LATCH = 5'h10
    } frr_state_t;
endpackage : frr_pkg

// file: hw/frr_timer.sv
`timescale 1ns/1ps
module frr_timer #(
    parameter int UNIT_CYC = frr_pkg::UNIT_CYC
) (
    input  wire logic       clk_sys, // System clock
    input  wire logic       rstn,    // Sync reset, low
    input  wire logic       load,    // Start a new delay
    input  wire logic [2:0] dly,     // Delay field
    output logic            done     // One-cycle pulse at the end
);
    logic [31:0]                  pre;
    logic [frr_pkg::UNITS_W-1:0]  units;
    logic                         busy;
    wire                          unit_end = (pre == 32'(UNIT_CYC - 1));
    wire                          last     = unit_end && (units == frr_pkg::UNITS_ONE);

    // Prescaler and unit countdown; a load restarts a running delay
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pre   <= 32'h0;
            units <= 8'h0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (load) begin
            pre   <= 32'h0;
            units <= frr_pkg::UNITS_ONE << dly;
            busy  <= 1'b1;
            done  <= 1'b0;
        end else begin
            pre   <= (busy && !unit_end) ? pre + 32'h1 : 32'h0;
            units <= (busy && unit_end) ? units - 8'h1 : units;
            busy  <= busy && !last;
            done  <= busy && last;
        end
    end

    unit_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        load |=> units == (frr_pkg::UNITS_ONE << $past(dly)))
        else $error("Delay unit count wrong");
endmodule : frr_timer

// file: hw/frr_retry_ctr.sv
`timescale 1ns/1ps
module frr_retry_ctr (
    input  wire logic       clk_sys, // System clock
    input  wire logic       rstn,    // Sync reset, low
    input  wire logic       clr,     // Back to zero
    input  wire logic       inc,     // One more attempt
    input  wire logic [2:0] limit,   // Attempts allowed
    output logic [2:0]      count,   // Attempts made
    output logic            spent    // All attempts used
);
    assign spent = (count >= limit);

    // Clear wins, a fresh fault always gets the full allowance
    always_ff @(posedge clk_sys) begin
        if (!rstn || clr) begin
            count <= 3'h0;
        end else if (inc && !spent) begin
            count <= count + 3'h1;
        end
    end

    // A reprogrammed limit mid-sequence is legal, so only the step itself is checked
    count_cap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !$past(clr) && count != $past(count) |-> $past(count) < $past(limit))
        else $error("Attempt count stepped past limit");
endmodule : frr_retry_ctr

// file: hw/frr_seq.sv
`timescale 1ns/1ps
module frr_seq #(
    parameter int UNIT_CYC = frr_pkg::UNIT_CYC
) (
    input  wire logic       clk_sys,      // System clock, 20 MHz
    input  wire logic       rstn,         // Sync reset, low
    input  wire logic [7:0] resp_cfg,     // Response byte
    input  wire logic       fault_in,     // Fault condition, level
    input  wire logic       ctrl_on,      // Control pin asks for on
    input  wire logic       op_on,        // Operation command asks for on
    input  wire logic       clr_bit,      // Per-bit status clear, pulse
    input  wire logic       clr_all,      // Clear-faults command, pulse
    input  wire logic       fault_reset,  // Reset input, level
    output logic            out_en,       // Output stage enable
    output logic            fault_latch,  // Fault status bit
    output logic            held_off,     // Held off until cleared
    output logic [2:0]      attempts,     // Restart attempts made
    output logic            retrying      // Retry sequence active
);
    frr_pkg::frr_state_t st;
    frr_pkg::frr_state_t next_st;

    logic en_prev;
    logic try_fail;
    logic tmr_load;
    logic tmr_done;
    logic ctr_inc;
    logic ctr_clr;
    logic spent;
    logic [2:0] cnt;

    // Field decode
    wire [1:0] resp  = resp_cfg[frr_pkg::RESP_HI:frr_pkg::RESP_LO];
    wire [2:0] retry = resp_cfg[frr_pkg::RETRY_HI:frr_pkg::RETRY_LO];
    wire [2:0] dly   = resp_cfg[frr_pkg::DLY_HI:frr_pkg::DLY_LO];

    // Continuous retry is not offered; that code behaves as no retry
    wire [2:0] limit = (retry == frr_pkg::RETRY_CONT) ? frr_pkg::RETRY_NONE : retry;
    wire       no_retry = (limit == frr_pkg::RETRY_NONE);

    // Enable is the pin and the command combined
    wire enable  = ctrl_on && op_on;
    wire en_rise = enable && !en_prev;

    // Any clearing event
    wire clr_any = clr_bit || clr_all || fault_reset || en_rise;

    // A fault counts only while the output is actually on
    wire fault_ev = fault_in && out_en && !fault_reset;

    wire s_run   = (st == frr_pkg::ST_RUN);
    wire s_grace = (st == frr_pkg::ST_GRACE);
    wire s_wait  = (st == frr_pkg::ST_WAIT);
    wire s_try   = (st == frr_pkg::ST_TRY);
    wire s_latch = (st == frr_pkg::ST_LATCH);

    // An attempt fails if the fault shows at any time while it runs
    wire next_fail = s_try && !tmr_done && (try_fail || fault_in);

    wire try_bad   = try_fail || fault_in;

    // Next state and timer and counter controls
    always_comb begin
        next_st  = st;
        tmr_load = 1'b0;
        ctr_inc  = 1'b0;
        ctr_clr  = 1'b0;
        if (clr_any) begin
            next_st = frr_pkg::ST_RUN;
            ctr_clr = 1'b1;
        end else begin
            unique case (st)
                frr_pkg::ST_RUN: begin
                    if (fault_ev) begin
                        unique case (resp)
                            frr_pkg::RESP_IGNORE: begin
                                next_st = frr_pkg::ST_RUN;
                            end
                            frr_pkg::RESP_RUNON: begin
                                next_st  = frr_pkg::ST_GRACE;
                                tmr_load = 1'b1;
                            end
                            frr_pkg::RESP_OFF: begin
                                next_st  = no_retry ? frr_pkg::ST_LATCH
                                                    : frr_pkg::ST_WAIT;
                                tmr_load = !no_retry;
                            end
                            frr_pkg::RESP_LATCH: begin
                                next_st = frr_pkg::ST_LATCH;
                            end
                        endcase
                    end
                end
                frr_pkg::ST_GRACE: begin
                    if (tmr_done && fault_in) begin
                        next_st  = no_retry ? frr_pkg::ST_LATCH
                                            : frr_pkg::ST_WAIT;
                        tmr_load = !no_retry;
                    end else if (tmr_done) begin
                        next_st = frr_pkg::ST_RUN;
                    end
                end
                frr_pkg::ST_WAIT: begin
                    if (tmr_done) begin
                        next_st  = frr_pkg::ST_TRY;
                        tmr_load = 1'b1;
                        ctr_inc  = 1'b1;
                    end
                end
                frr_pkg::ST_TRY: begin
                    if (tmr_done && try_bad && spent) begin
                        next_st = frr_pkg::ST_LATCH;
                    end else if (tmr_done && try_bad) begin
                        next_st  = frr_pkg::ST_TRY;
                        tmr_load = 1'b1;
                        ctr_inc  = 1'b1;
                    end else if (tmr_done) begin
                        next_st = frr_pkg::ST_RUN;
                        ctr_clr = 1'b1;
                    end
                end
                frr_pkg::ST_LATCH: begin
                    next_st = frr_pkg::ST_LATCH;
                end
                default: begin
                    next_st = frr_pkg::ST_LATCH;
                end
            endcase
        end
    end

    // Output follows the next state, so a shutdown lands one edge after the fault
    wire ns_on   = (next_st == frr_pkg::ST_RUN) || (next_st == frr_pkg::ST_GRACE);
    wire ns_try  = (next_st == frr_pkg::ST_TRY);
    wire ns_fail = ns_try && !tmr_load && next_fail;
    wire next_on = enable && (ns_on || (ns_try && !ns_fail));

    // Status bit: a new fault wins over a bit or command clear in the same cycle, but the reset input wins over a fault
    wire fault_set    = fault_ev && (resp != frr_pkg::RESP_IGNORE);
    wire next_flatch  = fault_set || (fault_latch && !clr_any);

    wire next_held    = (next_st == frr_pkg::ST_LATCH);
    wire next_retry   = (next_st == frr_pkg::ST_WAIT) || ns_try;

    // State and output registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st          <= frr_pkg::ST_RUN;
            en_prev     <= 1'b0;
            try_fail    <= 1'b0;
            out_en      <= 1'b0;
            fault_latch <= 1'b0;
            held_off    <= 1'b0;
            retrying    <= 1'b0;
        end else begin
            st          <= next_st;
            en_prev     <= enable;
            try_fail    <= ns_fail;
            out_en      <= next_on;
            fault_latch <= next_flatch;
            held_off    <= next_held;
            retrying    <= next_retry;
        end
    end

    // Attempts counter output is registered inside the counter
    assign attempts = cnt;

    frr_timer #(
        .UNIT_CYC (UNIT_CYC)
    ) u_timer (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .load    (tmr_load),
        .dly     (dly),
        .done    (tmr_done)
    );

    frr_retry_ctr u_ctr (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clr     (ctr_clr),
        .inc     (ctr_inc),
        .limit   (limit),
        .count   (cnt),
        .spent   (spent)
    );

    // Checks on the sequencer
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_hit(logic [1:0] code);
        s_run && fault_ev && !clr_any && resp == code;
    endsequence

    ignore_run_a: assert property (
        s_hit(frr_pkg::RESP_IGNORE) ##0 enable |=> out_en)
        else $error("Ignored fault dropped the output");

    runon_a: assert property (
        s_hit(frr_pkg::RESP_RUNON) ##0 enable |=> s_grace && out_en)
        else $error("Run-on fault did not keep running");

    grace_end_a: assert property (
        s_grace && tmr_done && !fault_in && !clr_any |=> s_run)
        else $error("Grace end without fault did not resume");

    off_now_a: assert property (
        s_hit(frr_pkg::RESP_OFF) |=> !out_en)
        else $error("Output not off after disable fault");

    latch_code_a: assert property (
        s_hit(frr_pkg::RESP_LATCH) |=> s_latch && held_off ##1 (!out_en || $past(clr_any)))
        else $error("Latching fault not held off");

    clr_bit_a: assert property (
        s_latch && clr_bit |=> s_run && !held_off)
        else $error("Bit clear did not release");

    clr_cmd_a: assert property (
        s_latch && clr_all |=> s_run && cnt == 3'h0)
        else $error("Clear command did not release");

    reset_in_a: assert property (
        fault_reset |=> s_run && !fault_latch)
        else $error("Reset input did not clear");

    cycle_on_a: assert property (
        s_latch && en_rise |=> s_run)
        else $error("Off-on cycle did not clear");

    no_retry_a: assert property (
        s_hit(frr_pkg::RESP_OFF) ##0 no_retry |=> s_latch ##1 (s_latch || $past(clr_any)))
        else $error("No-retry fault restarted");

    give_up_a: assert property (
        s_try && tmr_done && try_bad && spent && !clr_any |=> s_latch && !out_en)
        else $error("Exhausted retries did not latch");

    try_start_a: assert property (
        $rose(s_try) || (s_try && $past(s_try) && $past(tmr_done))
        |-> $past(tmr_done))
        else $error("Attempt started off the delay grid");

    ctr_zero_a: assert property (
        clr_any |=> cnt == 3'h0)
        else $error("Attempt count not cleared");
endmodule : frr_seq

// file: verification/frr_host.sv
`timescale 1ns/1ps
// Management bus host stand-in: turns bench requests into clear and on commands
module frr_host (
    input  wire logic clk_sys,         // System clock
    input  wire logic want_clr,        // Bench asks for a clear-faults command
    input  wire logic want_on,         // Bench asks for the on bit
    output logic      clr_all = 1'b0,  // Clear-faults command pulse
    output logic      op_on   = 1'b1   // Operation command on bit
);
    logic want_q = 1'b0; // Previous clear request

    // One pulse per request, so a held request cannot clear twice
    always_ff @(posedge clk_sys) begin
        want_q  <= want_clr;
        clr_all <= want_clr & ~want_q;
        op_on   <= want_on;
    end
endmodule : frr_host

// file: verification/frr_seq_test.sv
`timescale 1ns/1ps
module frr_seq_test;
    localparam int UC = 4; // Short time unit keeps the run brief
    logic       clk_sys, rstn, fault_in, ctrl_on, clr_bit, fault_reset;
    logic       want_clr, want_on, clr_all, op_on;
    logic       out_en, fault_latch, held_off, retrying;
    logic [7:0] resp_cfg;
    logic [2:0] attempts;
    int         err_count = 0;
    int         n_checks  = 0;

    frr_seq #(.UNIT_CYC(UC)) i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .resp_cfg(resp_cfg), .fault_in(fault_in),
        .ctrl_on(ctrl_on), .op_on(op_on), .clr_bit(clr_bit), .clr_all(clr_all),
        .fault_reset(fault_reset), .out_en(out_en), .fault_latch(fault_latch),
        .held_off(held_off), .attempts(attempts), .retrying(retrying));

    frr_host i_host (.clk_sys(clk_sys), .want_clr(want_clr), .want_on(want_on),
        .clr_all(clr_all), .op_on(op_on));

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // Wait n edges, then step past them so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %0b seen %0b", nm, e, g);
        end
    endtask : chk1

    task automatic chk3(input string nm, input logic [2:0] e, input logic [2:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk3

    // Remove the fault, apply one kind of clearing event, expect a clean restart
    task automatic clear_kind(input int k);
        @(posedge clk_sys) fault_in <= 1'b0;
        case (k)
            0: begin
                @(posedge clk_sys) clr_bit <= 1'b1;
                @(posedge clk_sys) clr_bit <= 1'b0;
            end
            1: begin
                @(posedge clk_sys) want_clr <= 1'b1;
                @(posedge clk_sys) want_clr <= 1'b0;
            end
            2: begin
                @(posedge clk_sys) fault_reset <= 1'b1;
                tick(3);
                chk1("latch_in_reset", 1'b0, fault_latch);
                @(posedge clk_sys) fault_reset <= 1'b0;
            end
            3: begin
                @(posedge clk_sys) ctrl_on <= 1'b0;
                tick(2);
                chk1("latch_while_off", 1'b1, fault_latch);
                @(posedge clk_sys) ctrl_on <= 1'b1;
            end
            default: begin
                @(posedge clk_sys) want_on <= 1'b0;
                repeat (3) @(posedge clk_sys);
                want_on <= 1'b1;
            end
        endcase
        tick(5);
        chk1("out_en_cleared", 1'b1, out_en);
        chk1("latch_cleared", 1'b0, fault_latch);
        chk1("held_cleared", 1'b0, held_off);
        chk3("attempts_cleared", 3'h0, attempts);
    endtask : clear_kind

    // Code 00: a long fault leaves the output running and nothing latched
    task automatic test_ignore();
        @(posedge clk_sys) resp_cfg <= 8'h00;
        fault_in <= 1'b1;
        tick(12);
        chk1("ignore_out_en", 1'b1, out_en);
        chk1("ignore_latch", 1'b0, fault_latch);
        @(posedge clk_sys) fault_in <= 1'b0;
        tick(2);
        $display("Test ignore done");
    endtask : test_ignore

    // Code 11: off and held after the fault goes away, then the clearing event of kind k
    task automatic test_latch(input int k);
        @(posedge clk_sys) resp_cfg <= 8'hc0;
        tick(2);
        chk1("latch_pre_on", 1'b1, out_en);
        @(posedge clk_sys) fault_in <= 1'b1;
        @(posedge clk_sys) fault_in <= 1'b0;
        tick(20);
        chk1("latch_out_en", 1'b0, out_en);
        chk1("latch_held", 1'b1, held_off);
        chk1("latch_bit", 1'b1, fault_latch);
        clear_kind(k);
        $display("Test latch with clear kind %0d done", k);
    endtask : test_latch

    // Code 01: output runs on for two to the delay field units, then goes off
    task automatic test_runon(input logic [2:0] d);
        int units;
        units = 1 << d;
        @(posedge clk_sys) resp_cfg <= {2'h1, 3'h0, d};
        fault_in <= 1'b1;
        tick(units * UC - 1);
        chk1("runon_still_on", 1'b1, out_en);
        tick(10);
        chk1("runon_off", 1'b0, out_en);
        chk1("runon_held", 1'b1, held_off);
        clear_kind(0);
        $display("Test run-on delay %0d done", d);
    endtask : test_runon

    // Code 10 with n retries on a fault that never goes away; each attempt turns the output on
    task automatic test_retry(input logic [2:0] n);
        logic       prev_on;
        logic [2:0] last;
        int         rises;
        int         t1;
        int         gap;
        prev_on = 1'b0;
        rises   = 0;
        last    = 3'h0;
        t1      = 0;
        gap     = 0;
        @(posedge clk_sys) resp_cfg <= {2'h2, n, 3'h1};
        fault_in <= 1'b1;
        tick(3);
        if (n != 3'h0) chk1("retrying", 1'b1, retrying);
        for (int c = 3; c < 90; c++) begin
            if (out_en && !prev_on) rises++;
            prev_on = out_en;
            if (attempts !== last) begin
                if (attempts == 3'h2) gap = c - t1;
                t1   = c;
                last = attempts;
            end
            tick(1);
        end
        chk3("retry_on_pulses", n, 3'(rises));
        chk1("retry_out_off", 1'b0, out_en);
        chk1("retry_held", 1'b1, held_off);
        chk1("retry_done", 1'b0, retrying);
        chk3("retry_count", n, attempts);
        if (n == 3'h2) chk1("retry_spacing", 1'b1, gap >= 2 * UC && gap <= 2 * UC + 2);
        clear_kind(0);
        $display("Test retry %0d done", n);
    endtask : test_retry

    // Watchdog sized well above the expected run of roughly 1200 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("Error watchdog expired");
        report_and_stop();
    end

    // Main sequence
    initial begin
        rstn        = 1'b0;
        resp_cfg    = 8'h00;
        fault_in    = 1'b0;
        ctrl_on     = 1'b1;
        clr_bit     = 1'b0;
        fault_reset = 1'b0;
        want_clr    = 1'b0;
        want_on     = 1'b1;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        tick(3);
        test_ignore();
        for (int k = 0; k < 5; k++) test_latch(k);
        test_runon(3'h0);
        test_runon(3'h7);
        test_retry(3'h0);
        test_retry(3'h1);
        test_retry(3'h2);
        test_retry(3'h2);
        report_and_stop();
    end
endmodule : frr_seq_test
